// ===== hdl/alarm_log_pkg.sv
// Package: widths, reset values and carrier types for the alarm logbook and fault classifier.
// Assumes a single 200 MHz clock domain shared by detectors, console and power stage.
package alarm_log_pkg;

  localparam int LOG_DEPTH = 5;
  localparam int CODE_W = 8;
  localparam int COUNT_W = 8;
  localparam int HOURS_W = 24;
  localparam int TEMP_W = 8;
  localparam int IDX_W = 3;

  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_FIRST = 8'h01;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hFF;
  localparam logic [HOURS_W-1:0] HOURS_RESET = 24'h00_0000;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h4;
  localparam logic [IDX_W-1:0] FILL_FULL = 3'h5;

  typedef enum logic {
    FAULT_WARNING,
    FAULT_ALARM
  } fault_class_t;

  // Warning cause: operator sequence or derating condition
  typedef enum logic {
    WARN_SEQUENCE,
    WARN_DERATE
  } warn_kind_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    fault_class_t cls;
    warn_kind_t kind;
  } fault_event_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [COUNT_W-1:0] count;
    logic [HOURS_W-1:0] hours;
    logic [TEMP_W-1:0] temp;
  } log_entry_t;

  typedef struct packed {
    logic bridge_enable;
    logic contactor_close;
    logic brake_release;
    logic derate;
    logic regen_stop;
  } power_cmd_t;

endpackage

// ===== hdl/fault_policy.sv
// Fault policy: turns the latched fault class into power stage commands.
// Assumes classification is done upstream; latched state is cleared by reset only.
`timescale 1ns/1ps
module fault_policy
  import alarm_log_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic event_valid,
  input wire alarm_log_pkg::fault_event_t event_in,
  input wire logic stop_on_warning,
  input wire logic contactor_safe,
  output alarm_log_pkg::power_cmd_t cmd
);

  logic alarm_latched;
  logic warn_latched;
  logic is_alarm;
  logic is_warn;

  assign is_alarm = event_valid && (event_in.cls == FAULT_ALARM);
  assign is_warn = event_valid && (event_in.cls == FAULT_WARNING);

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_latched <= 1'b0;
      warn_latched <= 1'b0;
    end else if (ce) begin
      if (is_alarm) alarm_latched <= 1'b1;
      if (is_warn) warn_latched <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Commands registered so outputs never glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd <= '0;
    end else if (ce) begin
      // Alarm opens the bridge; contactor and brake only when the contactor path is sound
      cmd.bridge_enable <= !(alarm_latched || is_alarm);
      cmd.contactor_close <= !((alarm_latched || is_alarm) && contactor_safe);
      cmd.brake_release <= !((alarm_latched || is_alarm) && contactor_safe);
      // Warnings keep the bridge on, derate or regen stop only
      cmd.derate <= (warn_latched || is_warn) && !stop_on_warning;
      cmd.regen_stop <= (warn_latched || is_warn) && stop_on_warning;
    end
  end

endmodule // fault_policy

// ===== hdl/alarm_logbook_fault_classifier.sv
// Top: five-entry alarm logbook with repeat merging, plus fault classification into alarm or warning.
// Assumes detectors and console run on CLK; contactor health input is a pin and is synchronised.
`timescale 1ns/1ps

// Notes on behaviour
// - Logbook holds exactly five alarm entries
// - Full logbook drops oldest, records newest
// - Entry keeps code, count, hours, temperature
// - Repeat of newest alarm bumps its count
// - Alarm opens bridge; contactor and brake only if contactor path safe
// - Warning keeps bridge, derates or regen-stops
// - Sequence errors and derating are warnings unless flagged safety
module alarm_logbook_fault_classifier
  import alarm_log_pkg::*;
#(
  parameter int DEPTH = alarm_log_pkg::LOG_DEPTH
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic FAULT_VALID,
  input wire logic [alarm_log_pkg::CODE_W-1:0] FAULT_CODE,
  input wire logic FAULT_IS_SAFETY,
  input wire logic FAULT_IS_SEQUENCE,
  input wire logic FAULT_IS_DERATE,
  input wire logic [alarm_log_pkg::HOURS_W-1:0] HOUR_METER,
  input wire logic [alarm_log_pkg::TEMP_W-1:0] INVERTER_TEMP,
  input wire logic STOP_ON_WARNING,
  input wire logic CONTACTOR_SAFE_PIN,
  input wire logic [alarm_log_pkg::IDX_W-1:0] READ_AGE,
  output alarm_log_pkg::log_entry_t READ_ENTRY,
  output logic READ_VALID,
  output logic [alarm_log_pkg::IDX_W-1:0] LOG_FILL,
  output alarm_log_pkg::power_cmd_t POWER_CMD
);

  import alarm_log_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Classification
  fault_event_t event_now;
  logic is_warning;

  // Sequence and derating faults open the power stage only when also flagged safety
  assign is_warning = (FAULT_IS_SEQUENCE || FAULT_IS_DERATE) && !FAULT_IS_SAFETY;
  assign event_now.code = FAULT_CODE;
  assign event_now.cls = is_warning ? FAULT_WARNING : FAULT_ALARM;
  assign event_now.kind = FAULT_IS_SEQUENCE ? WARN_SEQUENCE : WARN_DERATE;

  ////////////////////////////////////////////////////////////////////////
  // Contactor health pin synchroniser
  logic safe_meta;
  logic safe_sync;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      safe_meta <= 1'b0;
      safe_sync <= 1'b0;
    end else if (CE) begin
      safe_meta <= CONTACTOR_SAFE_PIN;
      safe_sync <= safe_meta;
    end
  end

  fault_policy u_policy (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .event_valid(FAULT_VALID),
    .event_in(event_now),
    .stop_on_warning(STOP_ON_WARNING),
    .contactor_safe(safe_sync),
    .cmd(POWER_CMD)
  );

  ////////////////////////////////////////////////////////////////////////
  // Logbook storage, a circular buffer indexed by write pointer
  log_entry_t book [DEPTH];
  logic [IDX_W-1:0] wr_ptr;
  logic [IDX_W-1:0] fill;

  function automatic logic [IDX_W-1:0] wrap_inc(input logic [IDX_W-1:0] p);
    return (p == IDX_W'(DEPTH - 1)) ? IDX_RESET : IDX_W'(p + 1'b1);
  endfunction

  function automatic logic [IDX_W-1:0] wrap_back(input logic [IDX_W-1:0] p, input logic [IDX_W-1:0] n);
    logic [IDX_W:0] t;
    t = {1'b0, p} + (IDX_W+1)'(DEPTH) - {1'b0, n};
    if (t >= (IDX_W+1)'(DEPTH)) t = t - (IDX_W+1)'(DEPTH);
    return t[IDX_W-1:0];
  endfunction

  logic [IDX_W-1:0] newest_idx;
  logic repeat_hit;
  logic do_merge;
  logic do_alloc;
  logic count_sat;

  // Only alarms are logged; warnings affect performance only
  assign newest_idx = wrap_back(wr_ptr, 3'h1);
  assign repeat_hit = (fill != IDX_RESET) && (book[newest_idx].code == FAULT_CODE);
  assign do_merge = CE && FAULT_VALID && !is_warning && repeat_hit;
  assign do_alloc = CE && FAULT_VALID && !is_warning && !repeat_hit;
  assign count_sat = (book[newest_idx].count == COUNT_MAX);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_ptr <= IDX_RESET;
      fill <= IDX_RESET;
    end else if (do_alloc) begin
      // Oldest slot is overwritten once full, pointer just keeps wrapping
      wr_ptr <= wrap_inc(wr_ptr);
      fill <= (fill == FILL_FULL) ? FILL_FULL : IDX_W'(fill + 1'b1);
    end
  end

  // Hours and temperature kept from the first occurrence only
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < DEPTH; i++) begin
        book[i] <= '{CODE_RESET, COUNT_RESET, HOURS_RESET, TEMP_RESET};
      end
    end else if (do_alloc) begin
      book[wr_ptr] <= '{FAULT_CODE, COUNT_FIRST, HOUR_METER, INVERTER_TEMP};
    end else if (do_merge && !count_sat) begin
      book[newest_idx].count <= COUNT_W'(book[newest_idx].count + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Console read port: age 0 is newest
  logic read_ok;
  logic [IDX_W-1:0] read_idx;

  assign read_ok = READ_AGE < fill;
  assign read_idx = wrap_back(wr_ptr, IDX_W'(READ_AGE + 1'b1));

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      READ_ENTRY <= '0;
      READ_VALID <= 1'b0;
      LOG_FILL <= IDX_RESET;
    end else if (CE) begin
      READ_ENTRY <= read_ok ? book[read_idx] : '0;
      READ_VALID <= read_ok;
      LOG_FILL <= fill;
    end
  end

endmodule // alarm_logbook_fault_classifier

// ===== verification/alarm_log_assertions.sv
// Checker: port timing of the logbook and the fault policy.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
module alarm_log_checker
  import alarm_log_pkg::*;
#(
  parameter int DEPTH = 5
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic FAULT_VALID,
  input wire logic FAULT_IS_SAFETY,
  input wire logic FAULT_IS_SEQUENCE,
  input wire logic FAULT_IS_DERATE,
  input wire logic [alarm_log_pkg::IDX_W-1:0] READ_AGE,
  input wire alarm_log_pkg::log_entry_t READ_ENTRY,
  input wire logic READ_VALID,
  input wire logic [alarm_log_pkg::IDX_W-1:0] LOG_FILL,
  input wire alarm_log_pkg::power_cmd_t POWER_CMD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence take; CE && FAULT_VALID; endsequence
  sequence alarm_in; take ##0 FAULT_IS_SAFETY; endsequence
  sequence warn_in; take ##0 !FAULT_IS_SAFETY && (FAULT_IS_SEQUENCE || FAULT_IS_DERATE); endsequence
  chk_fill_bound: assert property (LOG_FILL <= DEPTH) else $error("fill above depth");
  chk_fill_step: assert property ($changed(LOG_FILL) && !$past(SYS_RST) |->
    LOG_FILL == $past(LOG_FILL) + 3'h1) else $error("fill jumped");
  chk_alarm_open: assert property (alarm_in |=> !POWER_CMD.bridge_enable [*3]) else $error("bridge on");
  chk_warn_keep: assert property (warn_in ##0 POWER_CMD.bridge_enable |=> POWER_CMD.bridge_enable)
    else $error("warning cut bridge");
  chk_warn_act: assert property (warn_in ##0 POWER_CMD.bridge_enable |=>
    POWER_CMD.derate || POWER_CMD.regen_stop) else $error("warning ignored");
  chk_valid_age: assert property (!$past(SYS_RST) && $past(CE) |->
    READ_VALID == ($past(READ_AGE) < LOG_FILL)) else $error("valid wrong");
  chk_idle_zero: assert property (!READ_VALID |-> READ_ENTRY == '0) else $error("entry not blank");
  chk_count_live: assert property (READ_VALID |-> READ_ENTRY.count != COUNT_RESET)
    else $error("count zero");
endmodule // alarm_log_checker

bind alarm_logbook_fault_classifier alarm_log_checker #(.DEPTH(DEPTH)) u_chk(.CLK(CLK), .SYS_RST(SYS_RST),
  .CE(CE), .FAULT_VALID(FAULT_VALID), .FAULT_IS_SAFETY(FAULT_IS_SAFETY), .FAULT_IS_SEQUENCE(FAULT_IS_SEQUENCE),
  .FAULT_IS_DERATE(FAULT_IS_DERATE), .READ_AGE(READ_AGE), .READ_ENTRY(READ_ENTRY), .READ_VALID(READ_VALID),
  .LOG_FILL(LOG_FILL), .POWER_CMD(POWER_CMD));

// ===== verification/fault_source.sv
// Fault detector model: one-cycle event pulses with hour stamps.
// Assumes the bench calls send; drives on the falling edge.
`timescale 1ns/1ps
module fault_source (
  input wire logic clk,
  output logic valid,
  output logic [alarm_log_pkg::CODE_W-1:0] code,
  output logic [2:0] flags,
  output logic [alarm_log_pkg::HOURS_W-1:0] hours,
  output logic [alarm_log_pkg::TEMP_W-1:0] temp
);
  initial {valid, code, flags, hours, temp} = '0;
  task automatic send(input logic [7:0] c, input logic [2:0] f, input logic [23:0] h);
    @(negedge clk);
    valid = 1'b1;
    code = c;
    flags = f;
    hours = h;
    temp = h[7:0];
    @(negedge clk);
    valid = 1'b0;
    // Released lines toggle so stale data cannot pass
    code = ~c;
    flags = ~f;
    hours = ~h;
    temp = ~h[7:0];
  endtask
endmodule // fault_source

// ===== verification/alarm_logbook_fault_classifier_tb.sv
// Bench: warnings, fill, eviction, merging and saturation.
// Assumes fault_source and the bound checker are compiled.
`timescale 1ns/1ps
module alarm_logbook_fault_classifier_tb;
  import alarm_log_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic stop = 1'b0;
  logic ce = 1'b1;
  logic safe = 1'b1;
  logic [2:0] age = 3'h0;
  logic fv, rv;
  logic [2:0] fl, fill;
  logic [7:0] fc, tp;
  logic [23:0] hr;
  log_entry_t entry;
  power_cmd_t pc;
  int n_mismatch = 0;
  int total_checks = 0;
  initial forever #2.5 clk = ~clk;
  fault_source u_fault_source(.clk(clk), .valid(fv), .code(fc), .flags(fl), .hours(hr), .temp(tp));
  alarm_logbook_fault_classifier #(.DEPTH(LOG_DEPTH)) u_alarm_logbook_fault_classifier(.CLK(clk),
    .SYS_RST(sys_rst), .CE(ce), .FAULT_VALID(fv), .FAULT_CODE(fc), .FAULT_IS_SAFETY(fl[2]),
    .FAULT_IS_SEQUENCE(fl[1]), .FAULT_IS_DERATE(fl[0]), .HOUR_METER(hr), .INVERTER_TEMP(tp),
    .STOP_ON_WARNING(stop), .CONTACTOR_SAFE_PIN(safe), .READ_AGE(age), .READ_ENTRY(entry),
    .READ_VALID(rv), .LOG_FILL(fill), .POWER_CMD(pc));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic look(input logic [2:0] a, input logic [47:0] exp);
    @(negedge clk);
    age = a;
    @(negedge clk);
    check("entry", exp, entry);
    check("valid", {47'h0, exp != '0}, {47'h0, rv});
  endtask
  function automatic logic [47:0] ent(input logic [7:0] c, input logic [7:0] n, input logic [23:0] h);
    return {c, n, h, h[7:0]};
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_warn();
    u_fault_source.send(8'h30, 3'b010, 24'h00_0001);
    check("cmd", 48'h1e, {43'h0, pc});
    stop = 1'b1;
    u_fault_source.send(8'h31, 3'b001, 24'h00_0002);
    check("cmd", 48'h1d, {43'h0, pc});
    @(negedge clk);
    check("fill", 48'h0, {45'h0, fill});
    $display("warn done");
  endtask
  task automatic t_fill();
    for (int i = 0; i < 5; i++) begin
      u_fault_source.send(8'(17 + i), 3'b100, 24'(24'h10_0000 + i));
    end
    check("cmd", 48'h0, {45'h0, pc[4:2]});
    for (int i = 0; i < 5; i++) begin
      look(3'(i), ent(8'(21 - i), 8'h01, 24'(24'h10_0004 - i)));
    end
    look(3'h5, 48'h0);
    check("fill", 48'h5, {45'h0, fill});
    $display("fill done");
  endtask
  task automatic t_evict_merge();
    u_fault_source.send(8'h16, 3'b100, 24'h20_0000);
    look(3'h0, ent(8'h16, 8'h01, 24'h20_0000));
    look(3'h4, ent(8'h12, 8'h01, 24'h10_0001));
    check("fill", 48'h5, {45'h0, fill});
    repeat (2) u_fault_source.send(8'h16, 3'b100, 24'h30_0000);
    look(3'h0, ent(8'h16, 8'h03, 24'h20_0000));
    look(3'h1, ent(8'h15, 8'h01, 24'h10_0004));
    repeat (300) u_fault_source.send(8'h16, 3'b100, 24'h40_0000);
    look(3'h0, ent(8'h16, 8'hff, 24'h20_0000));
    $display("evict done");
  endtask
  // Mid-run reset, frozen enable, then an alarm with the contactor path unsafe
  task automatic t_reset();
    safe = 1'b0;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check("cmd", 48'h1c, {43'h0, pc});
    check("fill", 48'h0, {45'h0, fill});
    ce = 1'b0;
    u_fault_source.send(8'h40, 3'b100, 24'h50_0000);
    check("cmd", 48'h1c, {43'h0, pc});
    ce = 1'b1;
    u_fault_source.send(8'h41, 3'b100, 24'h50_0001);
    check("cmd", 48'h0c, {43'h0, pc});
    look(3'h0, ent(8'h41, 8'h01, 24'h50_0001));
    look(3'h1, 48'h0);
    $display("reset done");
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_warn();
    t_fill();
    t_evict_merge();
    t_reset();
    wrap_up();
  end
  // About 700 cycles expected; a hang stops well beyond that
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
endmodule // alarm_logbook_fault_classifier_tb
